//--- cmv_ac_host.sv
module cmv_ac_host import cmv_pkg::*; (
  // Link pins toward the codec
  output logic        bit_clk,
  output logic        sync,
  output logic        sdata_out,
  input  wire logic   sdata_in,
  // Read answers collected from the codec
  output logic        ans_stb,
  output logic [6:0]  ans_idx,
  output logic [15:0] ans_data
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HALF_NS = 32;

  initial begin
    bit_clk   = 1'b0;
    sync      = 1'b0;
    sdata_out = 1'b0;
    ans_stb   = 1'b0;
    ans_idx   = 7'h00;
    ans_data  = 16'h0000;
  end

  // One full frame; the clock stands low between frames
  task automatic frame(input logic rd, input logic wr, input logic [6:0] idx, input logic [15:0] data);
    logic [0:255] tx;
    logic [0:255] rx;
    tx        = '0;
    rx        = '0;
    tx[0]     = rd | wr;
    tx[1]     = rd | wr;
    tx[2]     = wr;
    tx[16]    = rd;
    tx[17:23] = idx;
    tx[36:51] = data;
    for (int k = 0; k < 256; k++) begin
      bit_clk   = 1'b1;
      sync      = (k < 16);
      sdata_out = tx[k];
      #HALF_NS;
      bit_clk   = 1'b0;
      rx[k]     = sdata_in;
      #HALF_NS;
    end
    sync      = 1'b0;
    sdata_out = 1'b0;
    // Only a ready frame with both status slots valid carries an answer
    if (rx[0] && rx[1] && rx[2]) begin
      ans_idx  = rx[17:23];
      ans_data = rx[36:51];
      ans_stb  = 1'b1;
      #1;
      ans_stb  = 1'b0;
    end
  endtask
endmodule // cmv_ac_host

//--- cmv_edge.sv
module cmv_edge import cmv_pkg::*; (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Synchronised level and its edges
  input  wire logic lvl,
  output logic      rise,
  output logic      fall
);

  logic prev_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lvl;
    end
  end

  assign rise = lvl & ~prev_r;
  assign fall = prev_r & ~lvl;

endmodule // cmv_edge

//--- cmv_mixer_regs.sv
// Functional notes
// - Capability index zero always reads 1990h
// - Write to index zero restores all defaults
// - Spatial capability field reads 00110
// - Capture, playback, alternate output flags read one
// - Master: mute, six-bit left, right attenuation
// - Master mute silences outputs; resets 8000h
// - Alternate: mute plus left, right attenuation
// - Alternate bit 13 saturates left to 011111
// - Alternate bit 5 saturates right to 011111
// - Mono: mute, six-bit attenuation, bit 5 saturates
// - Beep: mute, four-bit level, resets 0000h
// - Beep controls ignored while cold reset held
// - Phone: mute, five-bit gain, resets 8008h
// - Mic mute hits the selected microphone
// - Mic: five-bit gain, boost bit 6, 8008h
// - Stereo inputs: one mute for both channels
// - Stereo inputs: five-bit gains, resets 8808h
// - Reserved bits always read zero
// - Read answer comes in next frame slots
// - Accesses ignored while link not ready
module cmv_mixer_regs import cmv_pkg::*; #(
  parameter int READY_NS = READY_TIME_NS
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Serial link pins
  input  wire logic bit_clk,
  input  wire logic sync,
  input  wire logic sdata_out,
  input  wire logic cold_reset_n,
  output logic      sdata_in,
  // Mixer controls
  output cmv_mix_t  mix,
  output logic      link_ready
);

  localparam int               RDY_CYC  = (READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Counter sized from the delay so a long ready time cannot wrap early
  localparam int               RDY_W    = (RDY_CYC > 1) ? $clog2(RDY_CYC) : 1;
  localparam logic [RDY_W-1:0] RDY_LAST = RDY_W'(RDY_CYC - 1);

  logic [3:0]  pin_s;
  logic        bclk_s;
  logic        sync_s;
  logic        sdo_s;
  logic        cold_n_s;
  logic        bc_rise;
  logic        bc_fall;

  cmv_sync #(.W(4)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     ({bit_clk, sync, sdata_out, cold_reset_n}),
    .dout    (pin_s)
  );

  assign {bclk_s, sync_s, sdo_s, cold_n_s} = pin_s;

  // The link clock is only sampled; its edges become one-cycle enables
  cmv_edge u_edge (
    .ref_clk (ref_clk),
    .rst     (rst),
    .lvl     (bclk_s),
    .rise    (bc_rise),
    .fall    (bc_fall)
  );

  // Link readiness
  cmv_link_t   lk_r;
  cmv_link_t   lk_nxt;
  logic [RDY_W-1:0] rdy_cnt_r;
  logic [RDY_W-1:0] rdy_cnt_nxt;
  logic        cold_act;
  logic        link_up;

  assign cold_act = ~cold_n_s;
  assign link_up  = (lk_r == LK_UP);

  always_comb begin
    lk_nxt      = lk_r;
    rdy_cnt_nxt = rdy_cnt_r;
    case (lk_r)
      LK_COLD: begin
        rdy_cnt_nxt = '0;
        lk_nxt      = LK_WAIT;
      end
      LK_WAIT: begin
        if (rdy_cnt_r == RDY_LAST) begin
          lk_nxt = LK_UP;
        end else begin
          rdy_cnt_nxt = RDY_W'(rdy_cnt_r + 1'b1);
        end
      end
      LK_UP: begin
        lk_nxt = LK_UP;
      end
      default: begin
        lk_nxt = LK_COLD;
      end
    endcase
    if (cold_act) begin
      lk_nxt      = LK_COLD;
      rdy_cnt_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lk_r      <= LK_COLD;
      rdy_cnt_r <= '0;
    end else begin
      lk_r      <= lk_nxt;
      rdy_cnt_r <= rdy_cnt_nxt;
    end
  end

  // Register storage
  logic [15:0] reg_r   [NREG];
  logic [15:0] reg_nxt [NREG];
  cmv_cmd_t    cmd;
  logic        clr_all;
  logic [15:0] rd_data;
  logic [6:0]  rd_idx_r;

  function automatic logic [15:0] sanitize(input int s, input logic [15:0] d);
    logic [15:0] v;
    v = d & REG_MASK[s];
    if (s == SL_ALT && d[SAT_L_BIT]) begin
      v[13:8] = SAT_CODE;
    end
    if ((s == SL_ALT || s == SL_MONO) && d[SAT_R_BIT]) begin
      v[5:0] = SAT_CODE;
    end
    return v;
  endfunction

  function automatic logic [15:0] read_val(input logic [6:0] idx);
    logic [15:0] v;
    v = '0;
    if (idx == IDX_CAP) begin
      v = CAP_VALUE;
    end
    for (int i = 0; i < NREG; i++) begin
      if (idx == REG_IDX[i]) begin
        v = reg_r[i];
      end
    end
    return v;
  endfunction

  // A capability write restores every register default; writes there store nothing
  assign clr_all = cold_act | (cmd.wr & (cmd.idx == IDX_CAP));
  assign rd_data = read_val(rd_idx_r);

  for (genvar g = 0; g < NREG; g++) begin : g_reg
    always_comb begin
      reg_nxt[g] = reg_r[g];
      if (clr_all) begin
        reg_nxt[g] = REG_RST[g];
      end else if (cmd.wr && cmd.idx == REG_IDX[g]) begin
        reg_nxt[g] = sanitize(g, cmd.data);
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        reg_r[g] <= REG_RST[g];
      end else begin
        reg_r[g] <= reg_nxt[g];
      end
    end
  end

  // Frame tracking, command capture and read answer
  logic [7:0]  cnt_r;
  logic [7:0]  cnt_nxt;
  logic        in_frame_r;
  logic        in_frame_nxt;
  logic        sync_prev_r;
  logic        sync_prev_nxt;
  logic [54:0] rx_r;
  logic [54:0] rx_nxt;
  logic [55:0] rx_word;
  logic [55:0] tx_r;
  logic [55:0] tx_nxt;
  logic [55:0] tx_build;
  logic        sdin_nxt;
  logic        rd_pend_r;
  logic        rd_pend_nxt;
  logic [6:0]  rd_idx_nxt;
  logic [7:0]  out_idx;

  assign rx_word  = {rx_r, sdo_s};
  assign out_idx  = 8'(cnt_r + 8'd1);
  assign tx_build = {link_up, rd_pend_r, rd_pend_r, 13'h0000,
                     1'b0, rd_idx_r, 12'h000, rd_data, 4'h0};

  always_comb begin
    cnt_nxt       = cnt_r;
    in_frame_nxt  = in_frame_r;
    sync_prev_nxt = sync_prev_r;
    rx_nxt        = rx_r;
    tx_nxt        = tx_r;
    sdin_nxt      = sdata_in;
    rd_pend_nxt   = rd_pend_r;
    rd_idx_nxt    = rd_idx_r;
    cmd           = '0;
    if (bc_fall) begin
      sync_prev_nxt = sync_s;
      rx_nxt        = rx_word[54:0];
      if (sync_s && !sync_prev_r) begin
        cnt_nxt      = '0;
        in_frame_nxt = 1'b1;
      end else begin
        cnt_nxt = 8'(cnt_r + 8'd1);
      end
      if (in_frame_nxt && cnt_nxt == HDR_LAST_BIT && link_up &&
          rx_word[RX_TAG] && rx_word[RX_S1V]) begin
        cmd.rd   = rx_word[RX_RW];
        cmd.wr   = !rx_word[RX_RW] && rx_word[RX_S2V];
        cmd.idx  = rx_word[RX_IDX_HI:RX_IDX_LO];
        cmd.data = rx_word[RX_DAT_HI:RX_DAT_LO];
      end
      if (cmd.rd) begin
        rd_pend_nxt = 1'b1;
        rd_idx_nxt  = cmd.idx;
      end
    end
    if (bc_rise) begin
      if (!in_frame_r) begin
        sdin_nxt = 1'b0;
      end else if (out_idx == 8'd0) begin
        tx_nxt      = tx_build;
        sdin_nxt    = tx_build[55];
        rd_pend_nxt = 1'b0;
      end else if (out_idx < HDR_BITS) begin
        sdin_nxt = tx_r[6'(8'd55 - out_idx)];
      end else begin
        sdin_nxt = 1'b0;
      end
    end
    // A pending read dies with the link
    if (!link_up) begin
      rd_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r       <= 8'hff;
      in_frame_r  <= 1'b0;
      sync_prev_r <= 1'b0;
      rx_r        <= '0;
      tx_r        <= '0;
      sdata_in    <= 1'b0;
      rd_pend_r   <= 1'b0;
      rd_idx_r    <= '0;
    end else begin
      cnt_r       <= cnt_nxt;
      in_frame_r  <= in_frame_nxt;
      sync_prev_r <= sync_prev_nxt;
      rx_r        <= rx_nxt;
      tx_r        <= tx_nxt;
      sdata_in    <= sdin_nxt;
      rd_pend_r   <= rd_pend_nxt;
      rd_idx_r    <= rd_idx_nxt;
    end
  end

  // Mixer control outputs, one cycle behind the stored registers
  cmv_mix_t mix_nxt;
  logic     pick_second;

  assign pick_second = reg_r[SL_GP][PICK_BIT];

  always_comb begin
    mix_nxt                        = '0;
    mix_nxt.master_mute            = reg_r[SL_MASTER][MUTE_BIT];
    mix_nxt.left_out_atten         = reg_r[SL_MASTER][13:8];
    mix_nxt.right_out_atten        = reg_r[SL_MASTER][5:0];
    mix_nxt.alt_mute               = reg_r[SL_ALT][MUTE_BIT];
    mix_nxt.alt_left_atten         = reg_r[SL_ALT][13:8];
    mix_nxt.alt_right_atten        = reg_r[SL_ALT][5:0];
    mix_nxt.mono_mute              = reg_r[SL_MONO][MUTE_BIT];
    mix_nxt.mono_atten             = reg_r[SL_MONO][5:0];
    mix_nxt.phone_mute             = reg_r[SL_PHONE][MUTE_BIT];
    mix_nxt.phone_gain             = reg_r[SL_PHONE][4:0];
    mix_nxt.first_microphone_mute  = reg_r[SL_MIC][MUTE_BIT] & ~pick_second;
    mix_nxt.second_microphone_mute = reg_r[SL_MIC][MUTE_BIT] & pick_second;
    mix_nxt.mic_boost              = reg_r[SL_MIC][BOOST_BIT];
    mix_nxt.mic_gain               = reg_r[SL_MIC][4:0];
    // Beep stays at neutral settings while the cold reset pin is held
    if (!cold_act) begin
      mix_nxt.beep_mute  = reg_r[SL_BEEP][MUTE_BIT];
      mix_nxt.beep_level = reg_r[SL_BEEP][4:1];
    end
    for (int i = 0; i < NSTEREO; i++) begin
      mix_nxt.stereo_mute[i]      = reg_r[SL_STEREO + i][MUTE_BIT];
      mix_nxt.left_input_gain[i]  = reg_r[SL_STEREO + i][12:8];
      mix_nxt.right_input_gain[i] = reg_r[SL_STEREO + i][4:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mix        <= '0;
      link_ready <= 1'b0;
    end else begin
      mix        <= mix_nxt;
      link_ready <= link_up;
    end
  end

  // Checks on the design's own behaviour
  AST_CAP_READ: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_idx_r == IDX_CAP) |-> (rd_data == 16'h1990))
    else $error("capability read value wrong");

  AST_CAP_SPATIAL: assert property (@(posedge ref_clk) disable iff (rst)
    (bc_rise && in_frame_r && out_idx == 8'd0 && rd_pend_r && rd_idx_r == IDX_CAP)
    |=> (tx_r[18:14] == 5'b00110))
    else $error("spatial capability field wrong");

  AST_CAP_FLAGS: assert property (@(posedge ref_clk) disable iff (rst)
    (bc_rise && in_frame_r && out_idx == 8'd0 && rd_pend_r && rd_idx_r == IDX_CAP)
    |=> (tx_r[12] && tx_r[11] && tx_r[8]))
    else $error("capability feature flags wrong");

  AST_CAP_WRITE_CLEARS: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd.wr && cmd.idx == IDX_CAP)
    |=> (reg_r[SL_MASTER] == 16'h8000 && reg_r[SL_BEEP] == 16'h0000 && reg_r[SL_STEREO] == 16'h8808)
    ##1 (mix.master_mute && mix.stereo_mute[0]))
    else $error("capability write did not restore defaults");

  AST_ALT_LEFT_SAT: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd.wr && cmd.idx == 7'h04 && cmd.data[13] && !cold_act)
    |=> (reg_r[SL_ALT][13:8] == 6'b011111) ##1 (mix.alt_left_atten == 6'b011111))
    else $error("alternate left not saturated");

  AST_ALT_RIGHT_SAT: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd.wr && cmd.idx == 7'h04 && cmd.data[5] && !cold_act)
    |=> (reg_r[SL_ALT][5:0] == 6'b011111))
    else $error("alternate right not saturated");

  AST_MONO_SAT: assert property (@(posedge ref_clk) disable iff (rst)
    (cmd.wr && cmd.idx == 7'h06 && cmd.data[5] && !cold_act)
    |=> (reg_r[SL_MONO][5:0] == 6'b011111))
    else $error("mono attenuation not saturated");

  AST_BEEP_COLD: assert property (@(posedge ref_clk) disable iff (rst)
    cold_act [*2] |-> (mix.beep_mute == 1'b0 && mix.beep_level == 4'h0))
    else $error("beep controls active during cold reset");

  AST_MIC_PICK: assert property (@(posedge ref_clk) disable iff (rst)
    reg_r[SL_MIC][MUTE_BIT]
    |=> (mix.second_microphone_mute == $past(reg_r[SL_GP][PICK_BIT])) &&
        (mix.first_microphone_mute != $past(reg_r[SL_GP][PICK_BIT])))
    else $error("mic mute on wrong input");

  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    ((reg_r[SL_MASTER] & 16'h40c0) == 16'h0000) && ((reg_r[SL_STEREO] & 16'h60e0) == 16'h0000))
    else $error("reserved bits stored");

  AST_READ_ANSWER: assert property (@(posedge ref_clk) disable iff (rst)
    (bc_rise && in_frame_r && out_idx == 8'd0 && rd_pend_r && link_up)
    |=> (tx_r[54] && tx_r[53] && tx_r[38:32] == $past(rd_idx_r) && !rd_pend_r))
    else $error("read answer not placed in frame");

  AST_NOT_READY_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
    !link_up |-> (!cmd.wr && !cmd.rd) ##1 !rd_pend_r)
    else $error("access taken while link not ready");

endmodule // cmv_mixer_regs

//--- cmv_mixer_regs_bench.sv
module cmv_mixer_regs_bench import cmv_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        rst;
  logic        cold_reset_n;
  logic        bit_clk;
  logic        sync;
  logic        sdata_out;
  logic        sdata_in;
  logic        link_ready;
  logic        ans_stb;
  logic [6:0]  ans_idx;
  logic [15:0] ans_data;
  cmv_mix_t    mix;
  logic [15:0] exp_r [NREG];
  logic [22:0] exp_q [$];
  logic [15:0] rnd;
  int          errors;
  int          samples_checked;

  // Ready delay outlasts the command slots of a frame so an early access is seen ignored
  cmv_mixer_regs #(.READY_NS(4000)) i_cmv_mixer_regs (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .bit_clk      (bit_clk),
    .sync         (sync),
    .sdata_out    (sdata_out),
    .cold_reset_n (cold_reset_n),
    .sdata_in     (sdata_in),
    .mix          (mix),
    .link_ready   (link_ready)
  );

  cmv_ac_host i_cmv_ac_host (
    .bit_clk   (bit_clk),
    .sync      (sync),
    .sdata_out (sdata_out),
    .sdata_in  (sdata_in),
    .ans_stb   (ans_stb),
    .ans_idx   (ans_idx),
    .ans_data  (ans_data)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [15:0] stored(input int i, input logic [15:0] d);
    logic [15:0] v;
    v = d & REG_MASK[i];
    if (i == SL_ALT && d[SAT_L_BIT]) v[13:8] = SAT_CODE;
    if ((i == SL_ALT || i == SL_MONO) && d[SAT_R_BIT]) v[5:0] = SAT_CODE;
    return v;
  endfunction

  function automatic cmv_mix_t exp_mix();
    cmv_mix_t m;
    logic     pick;
    pick                     = exp_r[SL_GP][PICK_BIT];
    m.master_mute            = exp_r[SL_MASTER][MUTE_BIT];
    m.left_out_atten         = exp_r[SL_MASTER][13:8];
    m.right_out_atten        = exp_r[SL_MASTER][5:0];
    m.alt_mute               = exp_r[SL_ALT][MUTE_BIT];
    m.alt_left_atten         = exp_r[SL_ALT][13:8];
    m.alt_right_atten        = exp_r[SL_ALT][5:0];
    m.mono_mute              = exp_r[SL_MONO][MUTE_BIT];
    m.mono_atten             = exp_r[SL_MONO][5:0];
    m.beep_mute              = exp_r[SL_BEEP][MUTE_BIT];
    m.beep_level             = exp_r[SL_BEEP][4:1];
    m.phone_mute             = exp_r[SL_PHONE][MUTE_BIT];
    m.phone_gain             = exp_r[SL_PHONE][4:0];
    m.first_microphone_mute  = exp_r[SL_MIC][MUTE_BIT] & ~pick;
    m.second_microphone_mute = exp_r[SL_MIC][MUTE_BIT] & pick;
    m.mic_boost              = exp_r[SL_MIC][BOOST_BIT];
    m.mic_gain               = exp_r[SL_MIC][4:0];
    for (int j = 0; j < NSTEREO; j++) begin
      m.stereo_mute[j]      = exp_r[SL_STEREO + j][MUTE_BIT];
      m.left_input_gain[j]  = exp_r[SL_STEREO + j][12:8];
      m.right_input_gain[j] = exp_r[SL_STEREO + j][4:0];
    end
    return m;
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      errors++;
      $display("unexpected value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    i_cmv_ac_host.frame(1'b0, 1'b1, idx, d);
  endtask

  // The answer shows up during the following frame
  task automatic rd(input logic [6:0] idx, input logic [15:0] e);
    exp_q.push_back({idx, e});
    i_cmv_ac_host.frame(1'b1, 1'b0, idx, 16'h0000);
  endtask

  task automatic reset_model();
    foreach (exp_r[i]) exp_r[i] = REG_RST[i];
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (link_ready !== 1'b1 && n < 8000) begin
      @(negedge ref_clk);
      n++;
    end
    check(128'(link_ready), 128'h1);
  endtask

  always @(posedge ans_stb) begin
    if (exp_q.size() == 0) begin
      errors++;
      $display("unexpected answer at %0t: %h", $time, {ans_idx, ans_data});
    end else begin
      check(128'({ans_idx, ans_data}), 128'(exp_q.pop_front()));
    end
  end

  initial begin
    #400000;
    errors++;
    $display("watchdog expired at %0t", $time);
    conclude();
  end

  initial begin
    logic [15:0] d;
    rst             = 1'b1;
    cold_reset_n    = 1'b0;
    errors          = 0;
    samples_checked = 0;
    rnd             = 16'h000c;
    reset_model();
    repeat (4) @(negedge ref_clk);
    rst          = 1'b0;
    cold_reset_n = 1'b1;
    wait_ready();
    check(128'(mix), 128'(exp_mix()));
    rd(IDX_CAP, 16'h1990);
    // Saturation, boost, mute and pick bits forced so every special case is hit
    for (int i = 0; i < NREG; i++) begin
      rnd = lfsr(rnd);
      d = rnd | (i == SL_ALT ? 16'h2020 : i == SL_MONO ? 16'h0020 : i == SL_BEEP ? 16'h001e :
                 i == SL_MIC ? 16'h8040 : i == SL_GP ? 16'h0100 : 16'h0000);
      wr(REG_IDX[i], d);
      exp_r[i] = stored(i, d);
      check(128'(mix), 128'(exp_mix()));
    end
    // Mic muted with the first input picked, then the second; the second route stands here
    check(128'(mix), 128'(exp_mix()));
    rd(REG_IDX[SL_ALT], exp_r[SL_ALT]);
    rd(REG_IDX[SL_MONO], exp_r[SL_MONO]);
    rd(REG_IDX[SL_BEEP], exp_r[SL_BEEP]);
    rd(REG_IDX[SL_STEREO + 4], exp_r[SL_STEREO + 4]);
    rd(7'h1a, 16'h0000);
    rnd = lfsr(rnd);
    wr(IDX_CAP, rnd);
    reset_model();
    check(128'(mix), 128'(exp_mix()));
    rd(IDX_CAP, 16'h1990);
    rd(REG_IDX[SL_MASTER], 16'h8000);
    wr(REG_IDX[SL_BEEP], 16'h801e);
    exp_r[SL_BEEP] = 16'h801e;
    check(128'(mix), 128'(exp_mix()));
    @(negedge ref_clk);
    cold_reset_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    check(128'(link_ready), 128'h0);
    reset_model();
    check(128'(mix), 128'(exp_mix()));
    @(negedge ref_clk);
    cold_reset_n = 1'b1;
    // Sent before the link reports ready, so it must leave no trace
    wr(REG_IDX[SL_MASTER], 16'h0000);
    wait_ready();
    check(128'(mix), 128'(exp_mix()));
    check(128'(exp_q.size()), 128'h0);
    conclude();
  end
endmodule // cmv_mixer_regs_bench

//--- cmv_pkg.sv
package cmv_pkg;

  // Core clock and derived link timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int READY_TIME_NS = 1000;
  localparam int READY_CYC     = (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Frame layout as seen on the serial link
  localparam logic [7:0] HDR_LAST_BIT = 8'd55;
  localparam logic [7:0] HDR_BITS     = 8'd56;
  localparam int         RX_TAG       = 55;
  localparam int         RX_S1V       = 54;
  localparam int         RX_S2V       = 53;
  localparam int         RX_RW        = 39;
  localparam int         RX_IDX_HI    = 38;
  localparam int         RX_IDX_LO    = 32;
  localparam int         RX_DAT_HI    = 19;
  localparam int         RX_DAT_LO    = 4;

  // Capability register
  localparam logic [6:0]  IDX_CAP   = 7'h00;
  localparam logic [15:0] CAP_VALUE = 16'h1990;

  // Register slots held in flip-flops
  localparam int NSTEREO   = 5;
  localparam int NREG      = 12;
  localparam int SL_MASTER = 0;
  localparam int SL_ALT    = 1;
  localparam int SL_MONO   = 2;
  localparam int SL_BEEP   = 3;
  localparam int SL_PHONE  = 4;
  localparam int SL_MIC    = 5;
  localparam int SL_STEREO = 6;
  localparam int SL_GP     = 11;

  localparam logic [6:0] REG_IDX [NREG] = '{7'h02, 7'h04, 7'h06, 7'h0a, 7'h0c, 7'h0e,
                                            7'h10, 7'h12, 7'h14, 7'h16, 7'h18, 7'h20};
  localparam logic [15:0] REG_RST [NREG] = '{16'h8000, 16'h8000, 16'h8000, 16'h0000, 16'h8008, 16'h8008,
                                             16'h8808, 16'h8808, 16'h8808, 16'h8808, 16'h8808, 16'h0000};
  localparam logic [15:0] REG_MASK [NREG] = '{16'hbf3f, 16'hbf3f, 16'h803f, 16'h801e, 16'h801f, 16'h805f,
                                              16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h9f1f, 16'h0100};

  // Field positions
  localparam int         MUTE_BIT  = 15;
  localparam int         BOOST_BIT = 6;
  localparam int         PICK_BIT  = 8;
  localparam int         SAT_L_BIT = 13;
  localparam int         SAT_R_BIT = 5;
  localparam logic [5:0] SAT_CODE  = 6'h1f;

  typedef enum logic [1:0] {
    LK_COLD = 2'b00,
    LK_WAIT = 2'b01,
    LK_UP   = 2'b11
  } cmv_link_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] idx;
    logic [15:0] data;
  } cmv_cmd_t;

  typedef struct packed {
    logic                      master_mute;
    logic [5:0]                left_out_atten;
    logic [5:0]                right_out_atten;
    logic                      alt_mute;
    logic [5:0]                alt_left_atten;
    logic [5:0]                alt_right_atten;
    logic                      mono_mute;
    logic [5:0]                mono_atten;
    logic                      beep_mute;
    logic [3:0]                beep_level;
    logic                      phone_mute;
    logic [4:0]                phone_gain;
    logic                      first_microphone_mute;
    logic                      second_microphone_mute;
    logic                      mic_boost;
    logic [4:0]                mic_gain;
    logic [NSTEREO-1:0]        stereo_mute;
    logic [NSTEREO-1:0][4:0]   left_input_gain;
    logic [NSTEREO-1:0][4:0]   right_input_gain;
  } cmv_mix_t;

endpackage

//--- cmv_sync.sv
module cmv_sync import cmv_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  // Only the second stage is read outside this module
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // cmv_sync
